// ### hw/radio_core_ctrl_diag_regs.sv
// Control, probe multiplexer and probe edge interrupt registers over APB.
`timescale 1ns/1ps
`default_nettype none
`include "radio_core_defs.svh"

module radio_core_ctrl_diag_regs #(
   parameter int PERMIT_SLOW_EDGES = `PERMIT_SLOW_EDGES
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         ce,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [31:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output var  logic [31:0]                  prdata,
   output var  logic                         pready,
   output var  logic                         pslverr,
   input  wire logic                         slow_clk,
   input  wire logic                         slow_timer_reset,
   input  wire logic                         deep_sleep_request,
   input  wire logic                         sleep_exit_irq,
   input  wire logic                         core_on_master_clk,
   input  wire logic                         slow_wake_irq,
   input  wire logic                         deep_sleep_flag_slow,
   input  wire logic                         xmem_fault_signal,
   input  wire radio_core_pkg::probe_words_t probe_in,
   output var  logic [5:0]                   master_clock_mhz,
   output var  logic                         core_powerdown_permit,
   output var  logic [7:0]                   port0_probe,
   output var  logic [3:0]                   port1_probe,
   output var  logic                         radio_core_fault_irq,
   output var  logic                         probe_event_irq
);

   function automatic logic [7:0] pick_word(
      input radio_core_pkg::probe_words_t w,
      input logic [1:0]                   sel
   );
      case (sel)
         2'h0:    pick_word = w.core_probe_word0;
         2'h1:    pick_word = w.core_probe_word1;
         2'h2:    pick_word = w.rf_probe_word0;
         default: pick_word = w.rf_probe_word1;
      endcase
   endfunction : pick_word

   // ---------------- APB decode ----------------
   logic hit_ctrl;
   logic hit_irq;
   logic setup;
   logic wr_done;
   logic rd_done;
   logic [31:0] next_prdata;
   logic [31:0] read_word;

   assign hit_ctrl = (paddr == `CTRL_TWO_ADDR);
   assign hit_irq  = (paddr == `PROBE_IRQ_ADDR);
   assign setup    = ce && psel && !penable;
   assign pready   = ce;
   assign pslverr  = psel && penable && !hit_ctrl && !hit_irq;
   assign wr_done  = ce && psel && penable && pwrite;
   assign rd_done  = ce && psel && penable && !pwrite && hit_irq;

   // ---------------- Synchronisers ----------------
   // Slow clock and slow-domain status pass two flops; the third flop only
   // serves the edge detector so the first stage is never read by logic.
   logic [2:0] slow_meta;
   logic [2:0] slow_sync;
   logic       slow_prev;
   logic       slow_rise;
   logic       src_flag;
   logic       slow_clk_meta;
   logic       slow_clk_sync;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_meta <= 3'h0;
         slow_sync <= 3'h0;
         slow_prev <= 1'b0;
      end else if (ce) begin
         slow_meta <= {core_on_master_clk, slow_wake_irq,
                       deep_sleep_flag_slow};
         slow_sync <= slow_meta;
         slow_prev <= slow_clk_sync;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_clk_meta <= 1'b0;
         slow_clk_sync <= 1'b0;
      end else if (ce) begin
         slow_clk_meta <= slow_clk;
         slow_clk_sync <= slow_clk_meta;
      end
   end

   assign slow_rise = slow_clk_sync && !slow_prev;
   assign src_flag  = slow_sync[2];

   // ---------------- Control register ----------------
   radio_core_pkg::ctrl_t ctrl;
   radio_core_pkg::ctrl_t next_ctrl;
   logic                  next_fault_irq;

   always_comb begin
      next_ctrl = ctrl;
      if (wr_done && hit_ctrl) begin
         next_ctrl.master_clock_mhz =
            pwdata[`MHZ_MSB:`MHZ_LSB];
         next_ctrl.probe_bus_bit_flip    = pwdata[`FLIP_BIT];
         next_ctrl.probe_bus_source_pick =
            pwdata[`PICK_MSB:`PICK_LSB];
         next_ctrl.xmem_fault_irq_mask   = pwdata[`FAULT_MASK_BIT];
         if (!pwdata[`EDGE_SEEN_BIT])
            next_ctrl.slow_clock_edge_seen = 1'b0;
         if (pwdata[`FAULT_CLEAR_BIT])
            next_ctrl.xmem_fault_flag = 1'b0;
      end
      // Hardware sets come last so an event in the clearing cycle survives.
      if (slow_rise && !slow_timer_reset)
         next_ctrl.slow_clock_edge_seen = 1'b1;
      if (xmem_fault_signal)
         next_ctrl.xmem_fault_flag = 1'b1;
      next_fault_irq = next_ctrl.xmem_fault_flag
                       && next_ctrl.xmem_fault_irq_mask;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl                      <= '0;
         ctrl.master_clock_mhz     <= `MHZ_RESET;
         ctrl.xmem_fault_irq_mask  <= `FAULT_MASK_RESET;
         radio_core_fault_irq      <= 1'b0;
      end else if (ce) begin
         ctrl                 <= next_ctrl;
         radio_core_fault_irq <= next_fault_irq;
      end
   end

   assign master_clock_mhz = ctrl.master_clock_mhz;

   // ---------------- Powerdown permit sequence ----------------
   radio_core_pkg::permit_state_t permit_state;
   radio_core_pkg::permit_state_t next_permit_state;
   logic [7:0] permit_count;
   logic [7:0] next_permit_count;
   logic       req_prev;

   always_comb begin
      next_permit_state = permit_state;
      next_permit_count = permit_count;
      case (permit_state)
         radio_core_pkg::PERMIT_IDLE: begin
            next_permit_count = 8'h00;
            if (deep_sleep_request && !req_prev)
               next_permit_state = radio_core_pkg::PERMIT_WAIT;
         end
         radio_core_pkg::PERMIT_WAIT: begin
            // The sequence advances only on slow clock edges.
            if (slow_rise) begin
               if (permit_count == 8'(PERMIT_SLOW_EDGES - 1))
                  next_permit_state = radio_core_pkg::PERMIT_GRANT;
               else
                  next_permit_count = permit_count + 8'h01;
            end
            if (sleep_exit_irq)
               next_permit_state = radio_core_pkg::PERMIT_IDLE;
         end
         radio_core_pkg::PERMIT_GRANT: begin
            if (sleep_exit_irq)
               next_permit_state = radio_core_pkg::PERMIT_IDLE;
         end
         default: next_permit_state = radio_core_pkg::PERMIT_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         permit_state <= radio_core_pkg::PERMIT_IDLE;
         permit_count <= 8'h00;
         req_prev     <= 1'b0;
      end else if (ce) begin
         permit_state <= next_permit_state;
         permit_count <= next_permit_count;
         req_prev     <= deep_sleep_request;
      end
   end

   assign core_powerdown_permit =
      (permit_state == radio_core_pkg::PERMIT_GRANT);

   // ---------------- Probe bus to pins ----------------
   logic [7:0] probe_bus;
   logic [7:0] next_port0;

   always_comb begin
      case (ctrl.probe_bus_source_pick)
         2'h0: probe_bus = {probe_in.core_probe_word2[7:5],
                            probe_in.core_probe_word1[4:3],
                            probe_in.core_probe_word0[2:0]};
         2'h1: probe_bus = {probe_in.core_probe_word2[7:5],
                            probe_in.core_probe_word1[4:3],
                            probe_in.core_probe_word0[2],
                            slow_sync[1], slow_sync[0]};
         2'h2: probe_bus = probe_in.rf_probe_word0;
         default: probe_bus = probe_in.rf_probe_word1;
      endcase
      if (ctrl.probe_bus_bit_flip)
         next_port0 = {<<{probe_bus}};
      else
         next_port0 = probe_bus;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port0_probe <= 8'h00;
         port1_probe <= 4'h0;
      end else if (ce) begin
         port0_probe <= next_port0;
         port1_probe <= next_port0[3:0];
      end
   end

   // ---------------- Probe edge channels 3..1 ----------------
   radio_core_pkg::chan_t chan [3:1];
   logic [3:1]            chan_pulse;

   genvar gi;
   generate
      for (gi = 1; gi <= 3; gi++) begin : g_chan
         radio_core_pkg::chan_t next_chan;
         logic [7:0]            sel_word;
         logic                  bit_now;
         logic                  bit_prev;
         logic                  armed;
         logic                  next_armed;
         logic                  hit;
         logic                  next_pulse;

         always_comb begin
            sel_word = pick_word(probe_in,
                                 chan[gi].probe_event_word_pick);
            bit_now  = sel_word[chan[gi].probe_event_bit_pick];
            // A reset or a new selection would look like an edge, so the
            // detector waits one cycle for bit_prev to catch up first.
            next_armed = !(wr_done && hit_irq);
            hit = armed && (chan[gi].probe_event_edge
                            ? (bit_prev && !bit_now)
                            : (!bit_prev && bit_now));
            next_chan = chan[gi];
            if (wr_done && hit_irq)
               next_chan = radio_core_pkg::chan_t'(
                  {chan[gi].probe_event_flag, pwdata[8*gi +: 7]});
            // Only a flag that the read returned is cleared.
            if (rd_done && prdata[8*gi+7])
               next_chan.probe_event_flag = 1'b0;
            if (hit)
               next_chan.probe_event_flag = 1'b1;
            next_pulse = next_chan.probe_event_flag
                         && !chan[gi].probe_event_flag
                         && chan[gi].probe_event_mask;
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               chan[gi]       <= `CHAN_RESET;
               bit_prev       <= 1'b0;
               armed          <= 1'b0;
               chan_pulse[gi] <= 1'b0;
            end else if (ce) begin
               chan[gi]       <= next_chan;
               bit_prev       <= bit_now;
               armed          <= next_armed;
               chan_pulse[gi] <= next_pulse;
            end
         end
      end
   endgenerate

   assign probe_event_irq = |chan_pulse;

   // ---------------- Read data ----------------
   // Read data is captured in the setup cycle, so the access cycle returns
   // it from a flop at the cost of no extra wait state.
   always_comb begin
      read_word = 32'h0000_0000;
      if (hit_ctrl) begin
         read_word[`MHZ_MSB:`MHZ_LSB] = ctrl.master_clock_mhz;
         read_word[`PERMIT_BIT]       = core_powerdown_permit;
         read_word[`EDGE_SEEN_BIT]    = ctrl.slow_clock_edge_seen;
         read_word[`CLK_SRC_BIT]      = src_flag;
         read_word[`FLIP_BIT]         = ctrl.probe_bus_bit_flip;
         read_word[`PICK_MSB:`PICK_LSB] = ctrl.probe_bus_source_pick;
         read_word[`FAULT_MASK_BIT]   = ctrl.xmem_fault_irq_mask;
         read_word[`FAULT_FLAG_BIT]   = ctrl.xmem_fault_flag;
      end else if (hit_irq) begin
         read_word = {chan[3], chan[2], chan[1], 8'h00};
      end
      next_prdata = setup ? read_word : prdata;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else
         prdata <= next_prdata;
   end

endmodule : radio_core_ctrl_diag_regs
`default_nettype wire

// ### hw/radio_core_defs.svh
// Offsets, field positions, reset values and counts of the radio control block.
`ifndef RADIO_CORE_DEFS_SVH
`define RADIO_CORE_DEFS_SVH

`define CTRL_TWO_ADDR      32'h4000_0200
`define PROBE_IRQ_ADDR     32'h4000_0204

`define MHZ_MSB            14
`define MHZ_LSB            9
`define PERMIT_BIT         8
`define EDGE_SEEN_BIT      7
`define CLK_SRC_BIT        6
`define FLIP_BIT           5
`define PICK_MSB           4
`define PICK_LSB           3
`define FAULT_MASK_BIT     2
`define FAULT_CLEAR_BIT    1
`define FAULT_FLAG_BIT     0

`define MHZ_RESET          6'h00
`define FAULT_MASK_RESET   1'b1
`define CHAN_RESET         8'h00

`define PERMIT_SLOW_EDGES  4

`endif

// ### hw/radio_core_pkg.sv
// Types shared by the radio control and probe register block.
package radio_core_pkg;

   typedef struct packed {
      logic [7:0] core_probe_word0;
      logic [7:0] core_probe_word1;
      logic [7:0] core_probe_word2;
      logic [7:0] rf_probe_word0;
      logic [7:0] rf_probe_word1;
   } probe_words_t;

   typedef struct packed {
      logic [5:0] master_clock_mhz;
      logic       probe_bus_bit_flip;
      logic [1:0] probe_bus_source_pick;
      logic       xmem_fault_irq_mask;
      logic       slow_clock_edge_seen;
      logic       xmem_fault_flag;
   } ctrl_t;

   typedef struct packed {
      logic       probe_event_flag;
      logic       probe_event_edge;
      logic [2:0] probe_event_bit_pick;
      logic [1:0] probe_event_word_pick;
      logic       probe_event_mask;
   } chan_t;

   typedef enum logic [1:0] {
      PERMIT_IDLE  = 2'b00,
      PERMIT_WAIT  = 2'b01,
      PERMIT_GRANT = 2'b10
   } permit_state_t;

endpackage : radio_core_pkg

// ### tb/radio_core_regs_checker.sv
// Port-level assertions for the radio control and probe register block.
`timescale 1ns/1ps
`default_nettype none
`include "radio_core_defs.svh"
module radio_core_regs_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sleep_exit_irq,
   input wire logic        xmem_fault_signal,
   input wire logic [5:0]  master_clock_mhz,
   input wire logic        core_powerdown_permit,
   input wire logic [7:0]  port0_probe,
   input wire logic [3:0]  port1_probe,
   input wire logic        radio_core_fault_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   assign wr = psel && penable && pwrite && ce;
   port1_copy_a: assert property (port1_probe == port0_probe[3:0])
      else $error("port1 pins differ from port0 low nibble");
   fault_cause_a: assert property ($rose(radio_core_fault_irq) |->
      $past(xmem_fault_signal) || $past(wr))
      else $error("fault irq rose with no fault and no write");
   fault_hold_a: assert property (radio_core_fault_irq && !wr |=>
      radio_core_fault_irq) else $error("fault irq dropped on its own");
   permit_drop_a: assert property (sleep_exit_irq && ce |=>
      !core_powerdown_permit) else $error("permit kept after sleep exit");
   permit_rise_a: assert property ($rose(core_powerdown_permit) |->
      !$past(sleep_exit_irq)) else $error("permit rose during sleep exit");
   mhz_hold_a: assert property (!(wr && paddr == `CTRL_TWO_ADDR) |=>
      $stable(master_clock_mhz)) else $error("mhz field moved unwritten");
   freeze_a: assert property (!ce |=> $stable(prdata) &&
      $stable(port0_probe)) else $error("state moved with ce low");
   pready_a: assert property (pready == ce)
      else $error("pready does not follow ce");
   refuse_a: assert property (psel && penable && paddr != `CTRL_TWO_ADDR
      && paddr != `PROBE_IRQ_ADDR |-> pslverr)
      else $error("unmapped access not refused");
   cover property ($rose(radio_core_fault_irq));
   cover property ($rose(core_powerdown_permit));
   cover property (psel && penable && pslverr);
endmodule : radio_core_regs_checker
bind radio_core_ctrl_diag_regs radio_core_regs_checker checker_i (
   .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .sleep_exit_irq, .xmem_fault_signal,
   .master_clock_mhz, .core_powerdown_permit, .port0_probe, .port1_probe,
   .radio_core_fault_irq);
`default_nettype wire

// ### tb/tb_radio_core_ctrl_diag_regs.sv
// Directed testbench for the radio control and probe register block.
`timescale 1ns/1ps
`default_nettype none
`include "radio_core_defs.svh"
module tb_radio_core_ctrl_diag_regs;
   localparam int EDGES = 4;
   logic        pclk = '0, presetn = '0, ce = '1, psel = '0, penable = '0;
   logic        pwrite = '0, slow_clk = '0, slow_timer_reset = '0;
   logic        deep_sleep_request = '0, sleep_exit_irq = '0;
   logic        core_on_master_clk = '0, slow_wake_irq = '1;
   logic        deep_sleep_flag_slow = '0, xmem_fault_signal = '0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
   logic        pready, pslverr, err, core_powerdown_permit;
   logic        radio_core_fault_irq, probe_event_irq;
   logic [5:0]  master_clock_mhz;
   logic [7:0]  port0_probe, exp;
   logic [3:0]  port1_probe;
   logic [7:0]  src [4] = '{8'hbd, 8'hbe, 8'h71, 8'h2e};
   radio_core_pkg::probe_words_t probe_in =
      {8'hc5, 8'h3a, 8'ha6, 8'h71, 8'h2e};
   int          bad_count = 0, tests_run = 0, irq_n = 0, n0;

   radio_core_ctrl_diag_regs #(
      .PERMIT_SLOW_EDGES(EDGES)
   ) radio_core_ctrl_diag_regs_i (
      .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .slow_clk, .slow_timer_reset,
      .deep_sleep_request, .sleep_exit_irq, .core_on_master_clk,
      .slow_wake_irq, .deep_sleep_flag_slow, .xmem_fault_signal, .probe_in,
      .master_clock_mhz, .core_powerdown_permit, .port0_probe, .port1_probe,
      .radio_core_fault_irq, .probe_event_irq);

   initial begin
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (probe_event_irq === 1'b1) irq_n++;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic chk(input string what, input logic [31:0] seen, want);
      tests_run++;
      if (seen !== want) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask : chk
   // The request is held until pready is sampled high or 40 cycles pass; then released.
   task automatic apb(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("[ERR] pready expected 1 seen %b", pready);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [31:0] a, want);
      apb(1'b0, a, '0);
      chk($sformatf("read %h", a), rd, want);
   endtask : rdc
   task automatic slow_edge();
      slow_clk <= 1'b1;
      cyc(8);
      slow_clk <= 1'b0;
      cyc(8);
   endtask : slow_edge

   task automatic t_reset();
      chk("mhz pins", master_clock_mhz, '0);
      rdc(`CTRL_TWO_ADDR, 32'h0000_0004);
      rdc(`PROBE_IRQ_ADDR, 32'h0000_0000);
      $display("test reset done");
   endtask : t_reset
   task automatic t_ctrl();
      core_on_master_clk <= 1'b1;
      apb(1'b1, `CTRL_TWO_ADDR, 32'hffff_ffff);
      rdc(`CTRL_TWO_ADDR, 32'h0000_7e7c);
      chk("mhz pins", master_clock_mhz, 32'h0000_003f);
      fork
         apb(1'b1, `CTRL_TWO_ADDR, 32'h0000_1004);
         begin
            @(posedge pclk);
            ce <= 1'b0;
            cyc(3);
            ce <= 1'b1;
         end
      join
      rdc(`CTRL_TWO_ADDR, 32'h0000_1044);
      apb(1'b1, 32'h4000_0208, 32'hffff_ffff);
      chk("unmapped err", err, 32'h0000_0001);
      rdc(`CTRL_TWO_ADDR, 32'h0000_1044);
      chk("mhz pins", master_clock_mhz, 32'h0000_0008);
      $display("test control done");
   endtask : t_ctrl
   task automatic t_probe();
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `CTRL_TWO_ADDR,
             {17'h0, 6'h08, 3'h0, i[2], i[1:0], 3'h4});
         cyc(2);
         exp = src[i[1:0]];
         if (i[2]) exp = {<<{exp}};
         chk("port0 pins", port0_probe, exp);
         chk("port1 pins", port1_probe, exp[3:0]);
      end
      $display("test probe bus done");
   endtask : t_probe
   task automatic t_fault();
      xmem_fault_signal <= 1'b1;
      cyc(1);
      xmem_fault_signal <= 1'b0;
      cyc(2);
      chk("fault irq", radio_core_fault_irq, 32'h1);
      rdc(`CTRL_TWO_ADDR, 32'h0000_107d);
      apb(1'b1, `CTRL_TWO_ADDR, 32'h0000_1038);
      cyc(1);
      chk("fault irq", radio_core_fault_irq, 32'h0);
      rdc(`CTRL_TWO_ADDR, 32'h0000_1079);
      apb(1'b1, `CTRL_TWO_ADDR, 32'h0000_103e);
      cyc(1);
      chk("fault irq", radio_core_fault_irq, 32'h0);
      rdc(`CTRL_TWO_ADDR, 32'h0000_107c);
      $display("test fault done");
   endtask : t_fault
   task automatic t_slow();
      slow_timer_reset <= 1'b1;
      slow_edge();
      rdc(`CTRL_TWO_ADDR, 32'h0000_107c);
      slow_timer_reset <= 1'b0;
      slow_edge();
      rdc(`CTRL_TWO_ADDR, 32'h0000_10fc);
      apb(1'b1, `CTRL_TWO_ADDR, 32'h0000_10bc);
      rdc(`CTRL_TWO_ADDR, 32'h0000_10fc);
      apb(1'b1, `CTRL_TWO_ADDR, 32'h0000_103c);
      rdc(`CTRL_TWO_ADDR, 32'h0000_107c);
      $display("test slow clock done");
   endtask : t_slow
   task automatic t_permit();
      deep_sleep_request <= 1'b1;
      repeat (EDGES - 1) slow_edge();
      chk("permit early", core_powerdown_permit, 32'h0);
      slow_edge();
      chk("permit", core_powerdown_permit, 32'h1);
      sleep_exit_irq <= 1'b1;
      cyc(1);
      sleep_exit_irq <= 1'b0;
      deep_sleep_request <= 1'b0;
      cyc(2);
      chk("permit cleared", core_powerdown_permit, 32'h0);
      $display("test permit done");
   endtask : t_permit
   task automatic t_chan();
      apb(1'b1, `PROBE_IRQ_ADDR, 32'h3f44_13ff);
      rdc(`PROBE_IRQ_ADDR, 32'h3f44_1300);
      n0 = irq_n;
      probe_in.core_probe_word1[2] <= 1'b1;
      cyc(3);
      probe_in.rf_probe_word0[0] <= 1'b0;
      cyc(3);
      probe_in.rf_probe_word1[7] <= 1'b1;
      cyc(3);
      chk("irq pulses", irq_n - n0, 32'h2);
      rdc(`PROBE_IRQ_ADDR, 32'hbfc4_9300);
      rdc(`PROBE_IRQ_ADDR, 32'h3f44_1300);
      probe_in.core_probe_word1[2] <= 1'b0;
      probe_in.rf_probe_word1[7] <= 1'b0;
      cyc(3);
      rdc(`PROBE_IRQ_ADDR, 32'h3f44_1300);
      chk("irq pulses", irq_n - n0, 32'h2);
      apb(1'b1, `PROBE_IRQ_ADDR, 32'h0000_4100);
      cyc(2);
      probe_in.core_probe_word0[0] <= 1'b0;
      cyc(3);
      chk("irq pulses", irq_n - n0, 32'h3);
      rdc(`PROBE_IRQ_ADDR, 32'h0000_c100);
      $display("test probe events done");
   endtask : t_chan

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results

   initial begin
      cyc(20);
      presetn <= 1'b1;
      t_reset();
      t_ctrl();
      t_probe();
      t_fault();
      t_slow();
      t_permit();
      t_chan();
      results();
   end
   // The run needs well under a thousand cycles; a hang is cut off here.
   initial begin
      cyc(5000);
      bad_count++;
      results();
   end
endmodule : tb_radio_core_ctrl_diag_regs
`default_nettype wire
